// >>> include/eeprom_host_pkg.sv
// Package: pin timing constants, command and pin carrier types for the EEPROM host
package eeprom_host_pkg;

  localparam int CLK_PERIOD_PS = 4000;

  // Byte write strobe timing
  localparam int WRITE_PULSE_NS    = 150;
  localparam int ADDR_SETUP_NS     = 10;
  localparam int DATA_SETUP_NS     = 100;
  localparam int DATA_HOLD_NS      = 20;
  localparam int OE_SETUP_NS       = 10;
  localparam int POST_WRITE_MS     = 9;
  localparam int POST_WRITE_FRAC_US = 900;
  // Read access
  localparam int READ_ACCESS_NS    = 200;
  localparam int READ_FLOAT_NS     = 60;
  // Chip erase timing
  localparam int ERASE_SETUP_NS    = 500;
  localparam int ERASE_STROBE_MS   = 10;
  localparam int ERASE_ENABLE_US   = 5;
  localparam int ERASE_OUTPUT_US   = 3;
  localparam int ERASE_DATA_HOLD_NS = 100;

  // Millisecond figures overflow 32 bits once taken to picoseconds
  function automatic int ns_cycles(input int ns);
    longint c;
    c = (longint'(ns) * 64'sd1000 + longint'(CLK_PERIOD_PS) - 64'sd1) / longint'(CLK_PERIOD_PS);
    return (c < 64'sd1) ? 1 : int'(c);
  endfunction

  localparam int WRITE_PULSE_CYC   = ns_cycles(WRITE_PULSE_NS);
  localparam int ADDR_SETUP_CYC    = ns_cycles(ADDR_SETUP_NS);
  localparam int DATA_SETUP_CYC    = ns_cycles(DATA_SETUP_NS);
  localparam int DATA_HOLD_CYC     = ns_cycles(DATA_HOLD_NS);
  localparam int OE_SETUP_CYC      = ns_cycles(OE_SETUP_NS);
  localparam int READ_ACCESS_CYC   = ns_cycles(READ_ACCESS_NS);
  localparam int READ_FLOAT_CYC    = ns_cycles(READ_FLOAT_NS);
  localparam int ERASE_SETUP_CYC   = ns_cycles(ERASE_SETUP_NS);
  localparam int ERASE_DATA_HOLD_CYC = ns_cycles(ERASE_DATA_HOLD_NS);
  localparam int ERASE_ENABLE_CYC  = ns_cycles(ERASE_ENABLE_US * 1000);
  localparam int ERASE_OUTPUT_CYC  = ns_cycles((ERASE_ENABLE_US + ERASE_OUTPUT_US) * 1000);
  // Long counts, used as defaults of top parameters
  localparam int POST_WRITE_CYC    =
    ns_cycles(POST_WRITE_MS * 1000000 + POST_WRITE_FRAC_US * 1000);
  localparam int ERASE_STROBE_CYC  = ns_cycles(ERASE_STROBE_MS * 1000000);

  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;

  typedef enum logic [1:0] {
    CMD_READ  = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_ERASE = 2'h2,
    CMD_POLL  = 2'h3
  } cmd_type;

  typedef struct packed {
    logic              chip_enable_n;
    logic              output_enable_n;
    logic              erase_high_voltage_level;
    logic              write_enable_n;
    logic              addr_latch_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data_out;
    logic              data_oe;
  } pins_type;

  localparam pins_type PINS_IDLE = '{
    chip_enable_n: 1'b1, output_enable_n: 1'b1, erase_high_voltage_level: 1'b0,
    write_enable_n: 1'b1, addr_latch_n: 1'b1, addr: '0, data_out: '0, data_oe: 1'b0};

endpackage

// >>> design/eeprom_host.sv
// Host controller that drives a 512x8 parallel EEPROM through its pins
module eeprom_host
  import eeprom_host_pkg::*;
#(
  parameter int POST_WRITE_CYCLES  = POST_WRITE_CYC,
  parameter int ERASE_STROBE_CYCLES = ERASE_STROBE_CYC
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // Command port
  input  wire logic              cmd_valid,
  input  wire cmd_type           cmd,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0] cmd_data,
  output      logic              cmd_ready,
  output      logic              rsp_valid,
  output      logic [DATA_W-1:0] rsp_data,
  output      logic              poll_done,
  // Power transition hold request
  input  wire logic              power_unstable,
  // Device pins
  output      pins_type          pins,
  input  wire logic [DATA_W-1:0] data_in
);

  typedef enum logic [3:0] {
    ST_IDLE       = 4'h0,
    ST_RD_SETUP   = 4'h1,
    ST_RD_ACCESS  = 4'h2,
    ST_RD_FLOAT   = 4'h3,
    ST_WR_SETUP   = 4'h4,
    ST_WR_PULSE   = 4'h5,
    ST_WR_HOLD    = 4'h6,
    ST_WR_RECOVER = 4'h7,
    ST_ER_SETUP   = 4'h8,
    ST_ER_STROBE  = 4'h9,
    ST_ER_ENABLE  = 4'hA,
    ST_ER_OUTPUT  = 4'hB
  } state_type;

  typedef struct packed {
    state_type         state;
    logic [31:0]       count;
    logic              polling;
    logic [DATA_W-1:0] last_data;
    logic              cmd_ready;
    logic              rsp_valid;
    logic [DATA_W-1:0] rsp_data;
    logic              poll_done;
    pins_type          pins;
  } host_type;

  host_type r;
  host_type next_r;

  function automatic logic expired(input logic [31:0] count, input int cycles);
    return count >= 32'(cycles - 1);
  endfunction

  always_comb begin
    next_r           = r;
    next_r.count     = r.count + 32'h1;
    next_r.rsp_valid = 1'b0;
    next_r.poll_done = 1'b0;
    next_r.cmd_ready = 1'b0;
    case (r.state)
      ST_IDLE: begin
        next_r.count = '0;
        // Write enable held high while idle keeps writes inhibited
        next_r.pins = PINS_IDLE;
        if (cmd_valid && r.cmd_ready && !power_unstable) begin
          next_r.pins.chip_enable_n = 1'b0;
          next_r.pins.addr          = cmd_addr;
          next_r.polling            = (cmd == CMD_POLL);
          case (cmd)
            CMD_WRITE: begin
              next_r.pins.data_out = cmd_data;
              next_r.pins.data_oe  = 1'b1;
              next_r.last_data     = cmd_data;
              next_r.state         = ST_WR_SETUP;
            end
            CMD_ERASE: begin
              next_r.pins.erase_high_voltage_level = 1'b1;
              next_r.pins.data_out = '1;
              next_r.pins.data_oe  = 1'b1;
              next_r.state         = ST_ER_SETUP;
            end
            default: begin
              // Strobe pulsed low to latch the read address
              next_r.pins.addr_latch_n    = 1'b0;
              next_r.pins.output_enable_n = 1'b0;
              next_r.state                = ST_RD_SETUP;
            end
          endcase
        end else begin
          next_r.cmd_ready = !power_unstable;
        end
      end
      ST_RD_SETUP: begin
        next_r.pins.addr_latch_n = 1'b1;
        next_r.count = '0;
        next_r.state = ST_RD_ACCESS;
      end
      ST_RD_ACCESS: begin
        if (expired(r.count, READ_ACCESS_CYC)) begin
          next_r.rsp_valid = 1'b1;
          next_r.rsp_data  = data_in;
          // Bit seven matches once the internal write has finished
          next_r.poll_done = r.polling && (data_in[7] == r.last_data[7]);
          next_r.pins.output_enable_n = 1'b1;
          next_r.pins.chip_enable_n   = 1'b1;
          next_r.count = '0;
          next_r.state = ST_RD_FLOAT;
        end
      end
      ST_RD_FLOAT: begin
        // Let the device release the bus before we may drive it
        if (expired(r.count, READ_FLOAT_CYC)) begin
          next_r.state = ST_IDLE;
        end
      end
      ST_WR_SETUP: begin
        if (expired(r.count, OE_SETUP_CYC > ADDR_SETUP_CYC ? OE_SETUP_CYC : ADDR_SETUP_CYC)) begin
          next_r.pins.write_enable_n = 1'b0;
          next_r.count = '0;
          next_r.state = ST_WR_PULSE;
        end
      end
      ST_WR_PULSE: begin
        // Full width pulse, well above the noise filter
        if (expired(r.count, WRITE_PULSE_CYC > DATA_SETUP_CYC ? WRITE_PULSE_CYC
                                                            : DATA_SETUP_CYC)) begin
          next_r.pins.write_enable_n = 1'b1;
          next_r.count = '0;
          next_r.state = ST_WR_HOLD;
        end
      end
      ST_WR_HOLD: begin
        if (expired(r.count, DATA_HOLD_CYC)) begin
          next_r.pins.chip_enable_n = 1'b1;
          next_r.pins.data_oe       = 1'b0;
          next_r.rsp_valid          = 1'b1;
          next_r.count = '0;
          next_r.state = ST_WR_RECOVER;
        end
      end
      ST_WR_RECOVER: begin
        // Strobes stay high while the device runs its own erase/program
        if (expired(r.count, POST_WRITE_CYCLES)) begin
          next_r.state = ST_IDLE;
        end
      end
      ST_ER_SETUP: begin
        if (expired(r.count, ERASE_SETUP_CYC)) begin
          next_r.pins.write_enable_n = 1'b0;
          next_r.count = '0;
          next_r.state = ST_ER_STROBE;
        end
      end
      ST_ER_STROBE: begin
        if (expired(r.count, ERASE_STROBE_CYCLES)) begin
          next_r.pins.write_enable_n = 1'b1;
          next_r.count = '0;
          next_r.state = ST_ER_ENABLE;
        end
      end
      ST_ER_ENABLE: begin
        if (r.count == 32'(ERASE_DATA_HOLD_CYC)) begin
          next_r.pins.data_oe = 1'b0;
        end
        if (expired(r.count, ERASE_ENABLE_CYC)) begin
          next_r.pins.chip_enable_n = 1'b1;
          next_r.state = ST_ER_OUTPUT;
        end
      end
      ST_ER_OUTPUT: begin
        if (expired(r.count, ERASE_OUTPUT_CYC)) begin
          next_r.pins.erase_high_voltage_level = 1'b0;
          next_r.rsp_valid = 1'b1;
          next_r.state     = ST_IDLE;
        end
      end
      default: begin
        next_r = '0;
        next_r.state = ST_IDLE;
        next_r.pins  = PINS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r       <= '0;
      r.state <= ST_IDLE;
      r.pins  <= PINS_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign cmd_ready = r.cmd_ready;
  assign rsp_valid = r.rsp_valid;
  assign rsp_data  = r.rsp_data;
  assign poll_done = r.poll_done;
  assign pins      = r.pins;

endmodule

// >>> test/eeprom_host_monitor.sv
// Checker on the host controller's ports: pin sequencing and command handshake
module eeprom_host_monitor
  import eeprom_host_pkg::*;
#(
  parameter int POST_WRITE_CYCLES   = POST_WRITE_CYC,
  parameter int ERASE_STROBE_CYCLES = ERASE_STROBE_CYC
) (
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic              cmd_valid,
  input wire cmd_type           cmd,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_data,
  input wire logic              cmd_ready,
  input wire logic              rsp_valid,
  input wire logic [DATA_W-1:0] rsp_data,
  input wire logic              poll_done,
  input wire logic              power_unstable,
  input wire pins_type          pins,
  input wire logic [DATA_W-1:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic hv   = pins.erase_high_voltage_level;
  wire logic ce_n = pins.chip_enable_n;
  wire logic we_n = pins.write_enable_n;
  // High samples of the write strobe since it was last low, saturating
  logic [31:0] since_we;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      since_we <= '1;
    end else if (!we_n) begin
      since_we <= '0;
    end else if (since_we != '1) begin
      since_we <= since_we + 32'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_read_gate: assert property (!pins.output_enable_n |-> we_n && !pins.data_oe)
    else $error("output enable low while writing or driving data");
  a_write_combo: assert property (!we_n && !hv |->
    !ce_n && pins.output_enable_n && pins.addr_latch_n && pins.data_oe)
    else $error("write strobe without write combination");
  a_addr_hold: assert property (!we_n && !hv |=>
    $stable(pins.addr) && $stable(pins.data_out))
    else $error("address or data moved around write strobe");
  a_we_width: assert property ($fell(we_n) |-> !we_n [*6])
    else $error("write strobe too short");
  a_write_recover: assert property ($rose(we_n) |=> !cmd_ready [*8])
    else $error("ready too soon after strobe");
  a_write_spacing: assert property ($fell(we_n) && !hv |->
    since_we >= 32'(POST_WRITE_CYCLES))
    else $error("write strobe too soon after previous write");
  a_erase_setup: assert property ($fell(we_n) && hv |-> $past(hv, 125))
    else $error("erase strobe without setup time");
  a_erase_data: assert property (hv && !we_n |-> pins.data_oe && pins.data_out == 8'hFF)
    else $error("erase without all-high data");
  a_erase_release: assert property ($fell(hv) |-> ce_n && $past(ce_n, 750))
    else $error("high voltage dropped too early");
  a_power_block: assert property (power_unstable |=> !cmd_ready)
    else $error("ready while supply unstable");
  a_idle_pins: assert property (cmd_ready |-> ce_n && we_n && !pins.data_oe)
    else $error("pins not idle while ready");
  a_done_pulse: assert property (poll_done |-> rsp_valid ##1 !rsp_valid)
    else $error("poll flag not a single response pulse");

  c_write: cover property ($rose(we_n) && !hv);
  c_erase: cover property ($fell(hv));
  c_poll: cover property (poll_done);
endmodule

bind eeprom_host eeprom_host_monitor #(
  .POST_WRITE_CYCLES(POST_WRITE_CYCLES), .ERASE_STROBE_CYCLES(ERASE_STROBE_CYCLES)
) eeprom_host_monitor_inst (
  .core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_addr(cmd_addr),
  .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
  .poll_done(poll_done), .power_unstable(power_unstable), .pins(pins), .data_in(data_in));

// >>> test/eeprom_dev_model.sv
// Behavioural model of the 512x8 EEPROM, sampled on the host clock
module eeprom_dev_model
  import eeprom_host_pkg::*;
#(
  parameter int BUSY_CYCLES = 110
) (
  input  wire logic              core_clk,
  input  wire pins_type          pins,
  output logic [DATA_W-1:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [512];
  logic [ADDR_W-1:0] wr_addr = '0;
  logic [DATA_W-1:0] wr_data = 8'h00;
  logic              we_d    = 1'b1;
  int                busy    = 0;
  int                low_cnt = 0;

  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    data_in = 8'h00;
  end

  always @(posedge core_clk) begin
    we_d <= pins.write_enable_n;
    low_cnt <= pins.write_enable_n ? 0 : low_cnt + 1;
    if (busy > 0) busy <= busy - 1;
    if (busy == 1) mem[wr_addr] <= wr_data;
    if (we_d && !pins.write_enable_n) wr_addr <= pins.addr;
    // Short strobes and standby never start a write
    if (!we_d && pins.write_enable_n && !pins.chip_enable_n && low_cnt > 5) begin
      if (pins.erase_high_voltage_level && pins.data_out == 8'hFF) begin
        foreach (mem[i]) mem[i] <= 8'hFF;
      end else if (pins.output_enable_n && pins.addr_latch_n) begin
        wr_data <= pins.data_out;
        busy <= BUSY_CYCLES;
      end
    end
    // Plain reads ignore the latch strobe; a floating bus toggles
    if (!pins.chip_enable_n && !pins.output_enable_n) begin
      data_in <= (busy > 0 && pins.addr == wr_addr) ?
                 {~wr_data[7], wr_data[6:0]} : mem[pins.addr];
    end else begin
      data_in <= ~data_in;
    end
  end
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the EEPROM host controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import eeprom_host_pkg::*;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] busy_read;
  } row_type;
  logic              core_clk       = 1'b0;
  logic              rst_n          = 1'b0;
  logic              cmd_valid      = 1'b0;
  logic              power_unstable = 1'b0;
  cmd_type           cmd            = CMD_READ;
  logic [ADDR_W-1:0] cmd_addr       = '0;
  logic [DATA_W-1:0] cmd_data       = '0;
  logic [DATA_W-1:0] data_in, rsp_data;
  logic              cmd_ready, rsp_valid, poll_done;
  pins_type          pins;
  int                miscompares = 0;
  int                num_checks  = 0;
  int                cycles      = 0;
  row_type           rows [3] = '{'{9'h000, 8'hA5, 8'h25}, '{9'h1FF, 8'h5A, 8'hDA},
                                  '{9'h0AA, 8'h00, 8'h80}};

  eeprom_host #(.POST_WRITE_CYCLES(20), .ERASE_STROBE_CYCLES(20)) eeprom_host_inst (
    .core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .poll_done(poll_done), .power_unstable(power_unstable),
    .pins(pins), .data_in(data_in));
  eeprom_dev_model #(.BUSY_CYCLES(110)) eeprom_dev_model_inst (
    .core_clk(core_clk), .pins(pins), .data_in(data_in));

  initial forever #2 core_clk = ~core_clk;

  task automatic final_report();
    if (miscompares == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // Entered at a falling edge; request held until the edge that takes it
  task automatic run(input cmd_type c, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    cmd = c;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 5000) begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 9000) begin
      @(negedge core_clk);
      n++;
    end
    chk_flag(rsp_valid, 1'b1);
  endtask

  // Whole run needs a few thousand cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      $display("ERROR %0t run did not finish", $time);
      final_report();
    end
  end

  initial begin
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    chk_flag(pins.chip_enable_n, 1'b1);
    foreach (rows[i]) begin
      run(CMD_WRITE, rows[i].addr, rows[i].data);
      run(CMD_POLL, rows[i].addr, 8'h00);
      chk_flag(poll_done, 1'b0);
      chk_data(rsp_data, rows[i].busy_read);
      run(CMD_POLL, rows[i].addr, 8'h00);
      chk_flag(poll_done, 1'b1);
      run(CMD_READ, rows[i].addr, 8'h00);
      chk_data(rsp_data, rows[i].data);
    end
    run(CMD_ERASE, 9'h055, 8'h00);
    run(CMD_READ, rows[1].addr, 8'h00);
    chk_data(rsp_data, 8'hFF);
    power_unstable = 1'b1;
    cmd = CMD_WRITE;
    cmd_valid = 1'b1;
    // Long enough for the read float to end, so only the supply hold keeps ready low
    repeat (40) @(negedge core_clk);
    chk_flag(cmd_ready, 1'b0);
    chk_flag(pins.write_enable_n, 1'b1);
    chk_flag(pins.chip_enable_n, 1'b1);
    cmd_valid = 1'b0;
    power_unstable = 1'b0;
    @(negedge core_clk);
    run(CMD_READ, rows[0].addr, 8'h00);
    chk_data(rsp_data, 8'hFF);
    final_report();
  end
endmodule
